// *** bench/dsa_host.sv ***
// dsa_host: host model issuing serial command words to the alarm block
`timescale 1ns/100ps
`default_nettype none
module dsa_host (
  input wire logic clock,
  output logic cmd_valid,
  output logic [15:0] cmd_word,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  // idle bus after time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
  end
  // one byte write, strobe held over one rising edge
  task automatic wr8(input logic [6:0] addr, input logic [7:0] data);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_word = {1'b1, addr, data};
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_word = ~cmd_word; // released word shows no stale value
  endtask : wr8
  // sixteen bit value, high byte first, in the source's own format
  task automatic wr16(input logic [6:0] addr, input logic [15:0] v);
    wr8(addr + 7'h01, v[15:8]);
    wr8(addr, v[7:0]);
  endtask : wr16
  // read, answer taken one cycle after the command edge
  task automatic rd16(input logic [6:0] addr, output logic [15:0] v, output logic ok);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_word = {1'b0, addr, 8'h00};
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_word = ~cmd_word;
    ok = rd_valid;
    v = rd_data;
  endtask : rd16
endmodule : dsa_host
`default_nettype wire

// *** bench/dsa_top_tb_top.sv ***
// dsa_top_tb_top: self-checking bench for the dual sensor alarm monitor
`timescale 1ns/100ps
`default_nettype none
module dsa_top_tb_top;
  import dsa_pkg::*;
  localparam int SC = 8; // short sample period for simulation
  logic clock, rst_b, cmd_valid, rd_valid, sample_tick, chk_en;
  logic [15:0] cmd_word, rd_data, diagnostic_status, ctrl;
  logic [NUM_SRC-1:0][15:0] sr, sf, stp_r, stp_f; // sensor words, ramp steps
  logic dio_a, dio_a_oe_b, dio_b, dio_b_oe_b;
  logic [15:0] thr [2]; // bench copy of thresholds
  logic [15:0] win [2]; // bench copy of windows
  logic [15:0] hist [2][256]; // selected words, ring per alarm
  int hn [2]; // words stored per alarm
  logic [1:0] ef, kn; // expected flags, flags known
  int error_cnt, checks_done, due, seed;

  // free running clock
  initial clock = 1'b0;
  always #5 clock = ~clock;

  dsa_top #(.SAMPLE_CYCLES(SC)) dsa_top_i (.clock(clock), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .rd_data(rd_data), .rd_valid(rd_valid),
    .sensor_raw(sr), .sensor_filtered(sf), .diagnostic_status(diagnostic_status),
    .sample_tick(sample_tick), .digital_io_line_a(dio_a),
    .digital_io_line_a_oe_b(dio_a_oe_b), .digital_io_line_b(dio_b),
    .digital_io_line_b_oe_b(dio_b_oe_b));
  dsa_host dsa_host_i (.clock(clock), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .rd_data(rd_data), .rd_valid(rd_valid));

  // counted comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // read and compare, answer must be flagged
  task automatic rdchk(input logic [6:0] addr, input logic [15:0] exp);
    logic [15:0] v;
    logic ok;
    dsa_host_i.rd16(addr, v, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(v, exp);
  endtask : rdchk
  // source code to sensor index, -1 when disabled
  function automatic int src_idx(input logic [3:0] c);
    if (c >= 4'h1 && c <= 4'h7) return int'(c) - 1;
    if (c >= 4'h9 && c <= 4'hc) return int'(c) - 2;
    return -1;
  endfunction : src_idx
  // trigger test against signed threshold, equality never fires
  function automatic logic hit(input logic gt, input logic signed [16:0] v,
                               input logic [15:0] t);
    return gt ? (v > $signed({t[15], t})) : (v < $signed({t[15], t}));
  endfunction : hit

  // sensor words ramp every clock
  always @(negedge clock) begin
    for (int k = 0; k < NUM_SRC; k++) begin
      sr[k] <= sr[k] + stp_r[k];
      sf[k] <= sf[k] + stp_f[k];
    end
  end

  // flags and indicator against expectation, well after the tick
  task automatic check_outputs;
    logic act;
    act = ef[0] | ef[1];
    chk(diagnostic_status, {6'h0, ef, 8'h00});
    chk({14'h0, dio_a_oe_b, dio_b_oe_b},
        {14'h0, ~(ctrl[2] & ~ctrl[0]), ~(ctrl[2] & ctrl[0])});
    if (ctrl[2]) chk({15'h0, ctrl[0] ? dio_b : dio_a}, {15'h0, ctrl[1] ? act : ~act});
  endtask : check_outputs

  // reference model, evaluated at every internal sample while chk_en is set
  always @(posedge clock) begin : model
    int i, w;
    logic [15:0] x, y;
    logic signed [16:0] v;
    if (sample_tick === 1'b1 && chk_en) begin
      for (int a = 0; a < 2; a++) begin
        i = src_idx(ctrl[CTL_SRC_LO + 4*a +: 4]);
        w = (win[a][7:0] == 8'h00) ? 1 : int'(win[a][7:0]);
        ef[a] = 1'b0;
        kn[a] = 1'b1;
        if (i >= 0) begin
          x = ctrl[CTL_FILT] ? sf[i] : sr[i];
          hist[a][hn[a] % 256] = x;
          hn[a]++;
          v = $signed({x[15], x});
          if (ctrl[CTL_DYN_LO + a]) begin
            kn[a] = hn[a] > w;
            y = hist[a][(hn[a] + 255 - w) % 256];
            if (kn[a]) v = v - $signed({y[15], y});
          end
          ef[a] = kn[a] && hit(ctrl[CTL_GT_LO + a], v, thr[a]);
        end
      end
      due <= 5;
    end else if (due > 0) begin
      due <= due - 1;
      if (due == 1) check_outputs();
    end
  end

  // one configuration, then the larger window plus four samples
  task automatic scenario(input int n);
    logic [15:0] c;
    int wm;
    chk_en = 1'b0;
    repeat (SC) @(negedge clock);
    c = 16'($random(seed));
    c[15:12] = 4'(n + 5);
    c[11:8] = 4'(n);
    c[2] = (n % 4) != 3;
    for (int a = 0; a < 2; a++) begin
      thr[a] = 16'($random(seed) % 300);
      win[a] = (n % 5 == 0) ? 16'h0000 : 16'($random(seed) & 7);
    end
    if (n == 16) begin
      c = 16'h36af;
      thr[0] = 16'h0348;
      thr[1] = 16'h04e2;
      win[1] = 16'h0052;
    end
    if (n == 17) begin
      c = 16'hc9f4;
      win[0] = 16'h00ff;
      win[1] = 16'h0000;
    end
    for (int k = 0; k < NUM_SRC; k++) begin
      stp_r[k] <= 16'($random(seed) % 4);
      stp_f[k] <= 16'($random(seed) % 4);
    end
    dsa_host_i.wr16(ADDR_THR1, thr[0]);
    dsa_host_i.wr16(ADDR_THR2, thr[1]);
    dsa_host_i.wr16(ADDR_WIN1, win[0]);
    dsa_host_i.wr16(ADDR_WIN2, win[1]);
    dsa_host_i.wr8(ADDR_CTRL + 7'h01, c[15:8]);
    // low control byte right after a tick, restart lands clear of samples
    for (int k = 0; k <= SC; k++) begin
      @(posedge clock);
      if (sample_tick === 1'b1) break;
      if (k == SC) begin
        chk(16'h0000, 16'h0001);
        report_and_stop();
      end
    end
    dsa_host_i.wr8(ADDR_CTRL, c[7:0]);
    ctrl = c;
    hn[0] = 0;
    hn[1] = 0;
    chk_en = 1'b1;
    wm = ((win[0][7:0] > win[1][7:0]) ? int'(win[0][7:0]) : int'(win[1][7:0])) + 4;
    repeat (wm * SC) @(negedge clock);
    rdchk(ADDR_CTRL, c);
    rdchk(ADDR_WIN2, {8'h00, win[1][7:0]});
  endtask : scenario

  // reset, register checks, then alarm scenarios
  initial begin : main
    seed = 32'h30cb;
    rst_b = 1'b0;
    chk_en = 1'b0;
    due = 0;
    error_cnt = 0;
    checks_done = 0;
    ctrl = 16'h0000;
    for (int k = 0; k < NUM_SRC; k++) begin
      sr[k] = 16'($random(seed));
      sf[k] = 16'($random(seed));
      stp_r[k] = 16'h0000;
      stp_f[k] = 16'h0000;
    end
    repeat (20) @(posedge clock);
    @(negedge clock);
    rst_b = 1'b1;
    for (int k = 0; k < 5; k++) rdchk(ADDR_THR1 + 7'(2 * k), REG_RESET);
    chk({14'h0, dio_a_oe_b, dio_b_oe_b}, 16'h0003);
    dsa_host_i.wr8(ADDR_WIN1 + 7'h01, 8'hff);
    dsa_host_i.wr8(ADDR_WIN1, 8'ha5);
    rdchk(ADDR_WIN1, 16'h00a5);
    rdchk(7'h4a, 16'h0000);
    for (int n = 0; n < 18; n++) scenario(n);
    report_and_stop();
  end
endmodule : dsa_top_tb_top
`default_nettype wire

// *** logic/dsa_chan.sv ***
// dsa_chan: one alarm, static or rate-of-change, with sample history
`timescale 1ns/100ps
`default_nettype none
module dsa_chan
  import dsa_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic restart,
  input wire logic valid,
  input wire logic [15:0] word,
  input wire logic [15:0] thr,
  input wire logic [7:0] window,
  input wire logic dynamic,
  input wire logic greater,
  output logic flag
);
  typedef struct packed {
    logic [HIST_AW-1:0] wp; // next history slot
    logic [7:0] fill; // samples stored, saturating
    logic flag; // alarm condition
  } dsa_chan_st_t;
  dsa_chan_st_t st, next_st;
  logic [15:0] hist [0:(1<<HIST_AW)-1]; // past samples, no reset needed
  logic [7:0] span; // window, zero read as one
  logic [15:0] old; // sample from span ago
  logic signed [16:0] delta; // change over the window
  logic hit;

  // evaluate on each sample tick
  always_comb begin
    next_st = st;
    span = (window < WIN_MIN) ? WIN_MIN : window; // R06
    old = hist[st.wp - span]; // R18
    delta = 17'($signed({word[15], word}) - $signed({old[15], old})); // R05
    if (dynamic) begin
      hit = (st.fill >= span) && (greater ? (delta > $signed({thr[15], thr})) :
            (delta < $signed({thr[15], thr}))); // R05
    end else begin
      hit = greater ? ($signed(word) > $signed(thr)) : ($signed(word) < $signed(thr)); // R02 R03
    end
    if (restart) begin
      next_st.fill = 8'h00; // history no longer matches the setup
      next_st.flag = 1'b0;
    end else if (tick) begin // R17
      next_st.flag = valid && hit; // R08
      next_st.fill = !valid ? 8'h00 : (st.fill == FILL_MAX) ? FILL_MAX : st.fill + 8'h01;
      next_st.wp = st.wp + 8'h01;
    end
  end

  // state and history registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clock) begin
    if (tick && !restart) begin
      hist[st.wp] <= word; // R18
    end
  end

  assign flag = st.flag;

  AST_STATIC_CMP: assert property (@(posedge clock) disable iff (!rst_b) // R02
    tick && !restart && valid && !dynamic && greater && $signed(word) > $signed(thr)
    |=> flag) else $error("static alarm missed");
  AST_DYN_WAIT: assert property (@(posedge clock) disable iff (!rst_b) // R05
    tick && !restart && dynamic && st.fill == 8'h00 |=> !flag)
    else $error("dynamic alarm without history");
endmodule : dsa_chan
`default_nettype wire

// *** logic/dsa_pkg.sv ***
// dsa_pkg: shared constants of the dual sensor alarm monitor
package dsa_pkg;
  // register byte addresses in the serial command space
  localparam logic [6:0] ADDR_THR1 = 7'h40; // alarm1_threshold
  localparam logic [6:0] ADDR_THR2 = 7'h42; // alarm2_threshold
  localparam logic [6:0] ADDR_WIN1 = 7'h44; // alarm1_sample_window
  localparam logic [6:0] ADDR_WIN2 = 7'h46; // alarm2_sample_window
  localparam logic [6:0] ADDR_CTRL = 7'h48; // alarm_control
  localparam logic [15:0] REG_RESET = 16'h0000; // every register resets here
  // command word layout: write flag, address, data byte
  localparam int CMD_WRITE_BIT = 15;
  localparam int CMD_ADDR_LO = 8;
  localparam int CMD_ADDR_W = 7;
  // alarm_control field positions
  localparam int CTL_SRC_LO = 8; // alarm1 source nibble, alarm2 one nibble up
  localparam int CTL_SRC_W = 4;
  localparam int CTL_DYN_LO = 6; // alarm1 mode bit, alarm2 one up
  localparam int CTL_GT_LO = 4; // alarm1 polarity bit, alarm2 one up
  localparam int CTL_FILT = 3;
  localparam int CTL_IND_EN = 2;
  localparam int CTL_IND_POL = 1;
  localparam int CTL_IND_SEL = 0;
  // diagnostic_status alarm flag position
  localparam int STAT_ALARM_LO = 8;
  // source select codes
  localparam logic [3:0] SRC_OFF = 4'h0;
  localparam logic [3:0] SRC_GYRO_X = 4'h1;
  localparam logic [3:0] SRC_MAG_X = 4'h7;
  localparam logic [3:0] SRC_MAG_Y = 4'h9;
  localparam logic [3:0] SRC_TEMP = 4'hc;
  localparam int NUM_SRC = 11; // gyro xyz, accel xyz, mag xyz, pressure, temp
  // history depth and window limits
  localparam int HIST_AW = 8;
  localparam logic [7:0] WIN_MIN = 8'h01;
  localparam logic [7:0] FILL_MAX = 8'hff;
  // internal sample rate in milli-samples per second, and the clock
  localparam longint SAMPLE_RATE_MSPS = 819200;
  localparam longint CLOCK_HZ = 100000000;
  localparam int SAMPLE_DIV = int'((CLOCK_HZ * 1000) / SAMPLE_RATE_MSPS);
  localparam int DIV_W = 17;
endpackage : dsa_pkg

// *** logic/dsa_srcsel.sv ***
// dsa_srcsel: picks one sensor word by source select code
`timescale 1ns/100ps
`default_nettype none
module dsa_srcsel
  import dsa_pkg::*;
(
  input wire logic [3:0] code,
  input wire logic use_filt,
  input wire logic [NUM_SRC-1:0][15:0] raw,
  input wire logic [NUM_SRC-1:0][15:0] filt,
  output logic [15:0] word,
  output logic valid
);
  // chosen data set, filtered or not
  logic [NUM_SRC-1:0][15:0] pick;

  // code to index, with the gap at code 8 treated as disabled
  always_comb begin
    pick = use_filt ? filt : raw; // R12
    word = 16'h0000;
    valid = 1'b0;
    if (code >= SRC_GYRO_X && code <= SRC_MAG_X) begin
      word = pick[code - SRC_GYRO_X]; // R08
      valid = 1'b1;
    end else if (code >= SRC_MAG_Y && code <= SRC_TEMP) begin
      word = pick[code - 4'h2]; // R08
      valid = 1'b1;
    end
  end
endmodule : dsa_srcsel
`default_nettype wire

// *** logic/dsa_top.sv ***
// dsa_top: two condition alarms, command registers, status and indicator
//
// Contract
// (R01) two independent alarms, own threshold, polarity, source
// (R02) static mode compares source value with threshold
// (R03) threshold is signed, msb decides sign
// (R04) threshold uses source's format; host encodes it
// (R05) dynamic mode compares change over window
// (R06) window count low byte; zero and one mean one
// (R07) alarm flags in diagnostic status bits nine:eight
// (R08) second alarm source nibble encoding, zero disables
// (R09) first alarm nibble below, same encoding
// (R10) bits seven, six select dynamic mode
// (R11) bits five, four select greater-than triggering
// (R12) bit three selects filtered source data
// (R13) bit two enables indicator line
// (R14) bit one sets indicator active level
// (R15) bit zero picks second or first line
// (R16) window counted in internal samples at sample rate
// (R17) re-evaluate each sample; indicator ORs both flags
// (R18) change uses sample buffer up to 255 deep
`timescale 1ns/100ps
`default_nettype none
module dsa_top
  import dsa_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_DIV // clocks per internal sample
) (
  input wire logic clock,
  input wire logic rst_b,
  // command port, one 16-bit serial command word per strobe
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // sensor output words, raw and filtered
  input wire logic [NUM_SRC-1:0][15:0] sensor_raw,
  input wire logic [NUM_SRC-1:0][15:0] sensor_filtered,
  // status and tick
  output logic [15:0] diagnostic_status,
  output logic sample_tick,
  // two digital i/o lines, enable low while driving
  output logic digital_io_line_a,
  output logic digital_io_line_a_oe_b,
  output logic digital_io_line_b,
  output logic digital_io_line_b_oe_b
);
  // whole register state of the top
  typedef struct packed {
    logic [1:0][15:0] thr; // alarm thresholds
    logic [1:0][7:0] win; // alarm sample windows
    logic [15:0] ctrl; // alarm_control
    logic [15:0] rd_data; // read answer
    logic rd_valid; // read answer strobe
    logic [DIV_W-1:0] div_cnt; // sample divider
    logic tick; // internal sample enable
    logic restart; // setup changed
    logic [1:0] flags; // latched alarm flags
    logic io_a; // line a level
    logic io_a_oe_b; // line a not driven
    logic io_b; // line b level
    logic io_b_oe_b; // line b not driven
  } dsa_top_st_t;

  // lines released, everything else zero
  localparam dsa_top_st_t ST_RST = '{
    thr: {2{REG_RESET}},
    win: '0,
    ctrl: REG_RESET,
    rd_data: '0,
    rd_valid: 1'b0,
    div_cnt: '0,
    tick: 1'b0,
    restart: 1'b0,
    flags: 2'b00,
    io_a: 1'b0,
    io_a_oe_b: 1'b1,
    io_b: 1'b0,
    io_b_oe_b: 1'b1
  };

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_CYCLES - 1);

  dsa_top_st_t st, next_st;
  logic [CMD_ADDR_W-1:0] addr; // byte address of the command
  logic [CMD_ADDR_W-1:0] base; // word address
  logic hi; // odd address, upper byte
  logic wr; // write command
  logic rd; // read command
  logic [7:0] wbyte; // written byte
  logic [1:0] chan_flag; // alarm outputs of the channels
  logic active; // any alarm raised
  logic level; // indicator level when driving

  // per-alarm source select and evaluation
  for (genvar i = 0; i < 2; i++) begin : g_alarm
    logic [15:0] src_word; // selected sample
    logic src_valid; // source enabled

    dsa_srcsel u_sel (
      .code (st.ctrl[CTL_SRC_LO + CTL_SRC_W*i +: CTL_SRC_W]), // R08 R09
      .use_filt (st.ctrl[CTL_FILT]), // R12
      .raw (sensor_raw),
      .filt (sensor_filtered),
      .word (src_word),
      .valid (src_valid)
    );

    dsa_chan u_chan (
      .clock (clock),
      .rst_b (rst_b),
      .tick (st.tick), // R16
      .restart (st.restart),
      .valid (src_valid),
      .word (src_word),
      .thr (st.thr[i]), // R01 R04
      .window (st.win[i]), // R06
      .dynamic (st.ctrl[CTL_DYN_LO + i]), // R10
      .greater (st.ctrl[CTL_GT_LO + i]), // R11
      .flag (chan_flag[i])
    );
  end

  // command field split
  always_comb begin
    addr = cmd_word[CMD_ADDR_LO +: CMD_ADDR_W];
    base = {addr[CMD_ADDR_W-1:1], 1'b0};
    hi = addr[0];
    wbyte = cmd_word[7:0];
    wr = cmd_valid && cmd_word[CMD_WRITE_BIT];
    rd = cmd_valid && !cmd_word[CMD_WRITE_BIT];
  end

  // next state: divider, registers, reads, flags, indicator
  always_comb begin
    next_st = st;
    // internal sample rate
    if (st.div_cnt == DIV_LAST) begin
      next_st.div_cnt = '0;
      next_st.tick = 1'b1; // R16
    end else begin
      next_st.div_cnt = st.div_cnt + DIV_W'(1);
      next_st.tick = 1'b0;
    end
    // byte writes into registers
    next_st.restart = 1'b0;
    if (wr) begin
      case (base)
        ADDR_THR1: begin
          if (hi) begin
            next_st.thr[0][15:8] = wbyte; // R03
          end else begin
            next_st.thr[0][7:0] = wbyte;
          end
        end
        ADDR_THR2: begin
          if (hi) begin
            next_st.thr[1][15:8] = wbyte; // R03
          end else begin
            next_st.thr[1][7:0] = wbyte;
          end
        end
        ADDR_WIN1: begin
          if (!hi) begin
            next_st.win[0] = wbyte; // R06
          end
        end
        ADDR_WIN2: begin
          if (!hi) begin
            next_st.win[1] = wbyte; // R06
          end
        end
        ADDR_CTRL: begin
          if (hi) begin
            next_st.ctrl[15:8] = wbyte; // R08 R09
          end else begin
            next_st.ctrl[7:0] = wbyte; // R10 R11
          end
          next_st.restart = 1'b1; // history restarts on new setup
        end
        default: begin
          next_st.restart = 1'b0; // unmapped write ignored
        end
      endcase
    end
    // reads answer one cycle later
    next_st.rd_valid = rd;
    if (rd) begin
      case (base)
        ADDR_THR1: next_st.rd_data = st.thr[0];
        ADDR_THR2: next_st.rd_data = st.thr[1];
        ADDR_WIN1: next_st.rd_data = {8'h00, st.win[0]}; // R06
        ADDR_WIN2: next_st.rd_data = {8'h00, st.win[1]}; // R06
        ADDR_CTRL: next_st.rd_data = st.ctrl;
        default: next_st.rd_data = 16'h0000;
      endcase
    end
    // alarm flags and indicator
    next_st.flags = chan_flag; // R07
    active = |st.flags; // R17
    level = st.ctrl[CTL_IND_POL] ? active : !active; // R14
    next_st.io_a = 1'b0;
    next_st.io_b = 1'b0;
    next_st.io_a_oe_b = 1'b1;
    next_st.io_b_oe_b = 1'b1;
    if (st.ctrl[CTL_IND_EN]) begin // R13
      if (st.ctrl[CTL_IND_SEL]) begin // R15
        next_st.io_b = level;
        next_st.io_b_oe_b = 1'b0;
      end else begin
        next_st.io_a = level;
        next_st.io_a_oe_b = 1'b0;
      end
    end
  end

  // single state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  always_comb begin
    rd_data = st.rd_data;
    rd_valid = st.rd_valid;
    diagnostic_status = 16'h0000;
    diagnostic_status[STAT_ALARM_LO +: 2] = st.flags; // R07
    sample_tick = st.tick;
    digital_io_line_a = st.io_a;
    digital_io_line_a_oe_b = st.io_a_oe_b;
    digital_io_line_b = st.io_b;
    digital_io_line_b_oe_b = st.io_b_oe_b;
  end

  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // second window read answers exactly one cycle later
  AST_READ_ANSWER: assert property ( // R06
    rd && base == ADDR_WIN2 |=> rd_valid && rd_data == {8'h00, st.win[1]})
    else $error("window read wrong");
  // control write lands low byte
  AST_CTRL_WRITE: assert property ( // R10
    wr && base == ADDR_CTRL && !hi |=> st.ctrl[7:0] == $past(wbyte))
    else $error("control write lost");
  // threshold sign byte written
  AST_THR_SIGN: assert property ( // R03
    wr && base == ADDR_THR1 && hi |=> st.thr[0][15] == $past(cmd_word[7]))
    else $error("threshold msb lost");
  // window upper byte never stored
  AST_WIN_HI: assert property ( // R06
    wr && base == ADDR_WIN1 && hi |=> st.win[0] == $past(st.win[0]))
    else $error("window upper byte stored");
  // flags reach status one cycle after the channels
  AST_STATUS: assert property ( // R07
    ##1 diagnostic_status[STAT_ALARM_LO +: 2] == $past(chan_flag)
    && diagnostic_status[15:10] == 6'h00 && diagnostic_status[7:0] == 8'h00)
    else $error("status flags wrong");
  // indicator disabled leaves both lines undriven
  AST_IND_OFF: assert property ( // R13
    !st.ctrl[CTL_IND_EN] |=> digital_io_line_a_oe_b && digital_io_line_b_oe_b)
    else $error("indicator drives while disabled");
  // active-high on line a follows OR of flags
  AST_IND_POL: assert property ( // R14
    st.ctrl[CTL_IND_EN] && st.ctrl[CTL_IND_POL] && !st.ctrl[CTL_IND_SEL]
    |=> !digital_io_line_a_oe_b && digital_io_line_a == $past(|st.flags))
    else $error("indicator level wrong");
  // line select routes to line b
  AST_IND_SEL: assert property ( // R15
    st.ctrl[CTL_IND_EN] && st.ctrl[CTL_IND_SEL]
    |=> !digital_io_line_b_oe_b && digital_io_line_a_oe_b)
    else $error("indicator on wrong line");
  // sample tick is a single-cycle pulse
  AST_TICK: assert property ( // R16
    sample_tick |=> !sample_tick) else $error("tick longer than a cycle");
  // disabled second alarm source keeps its flag clear
  AST_SRC_OFF: assert property ( // R08
    st.tick && st.ctrl[CTL_SRC_LO+CTL_SRC_W +: CTL_SRC_W] == SRC_OFF && !st.restart
    |=> !chan_flag[1]) else $error("disabled alarm raised");
  // first alarm disabled keeps its flag clear
  AST_SRC1_OFF: assert property ( // R09
    st.tick && st.ctrl[CTL_SRC_LO +: CTL_SRC_W] == SRC_OFF && !st.restart |=> !chan_flag[0])
    else $error("disabled first alarm raised");
  // unused code between magnetometer x and y reads as disabled
  AST_SRC_GAP: assert property ( // R08
    st.tick && st.ctrl[CTL_SRC_LO+CTL_SRC_W +: CTL_SRC_W] == SRC_MAG_X + 4'h1 |=> !chan_flag[1])
    else $error("gap code raised alarm");
  // first threshold low byte written
  AST_THR1_LOW: assert property ( // R01
    wr && base == ADDR_THR1 && !hi |=> st.thr[0][7:0] == $past(wbyte))
    else $error("first threshold low byte lost");
  // second threshold low byte written
  AST_THR2_LOW: assert property ( // R01
    wr && base == ADDR_THR2 && !hi |=> st.thr[1][7:0] == $past(wbyte))
    else $error("second threshold low byte lost");
  // second threshold sign byte written
  AST_THR2_SIGN: assert property ( // R03
    wr && base == ADDR_THR2 && hi |=> st.thr[1][15] == $past(cmd_word[7]))
    else $error("second threshold msb lost");
  // first window low byte stored
  AST_WIN1_LOW: assert property ( // R06
    wr && base == ADDR_WIN1 && !hi |=> st.win[0] == $past(wbyte))
    else $error("first window lost");
  // second window low byte stored
  AST_WIN2_LOW: assert property ( // R06
    wr && base == ADDR_WIN2 && !hi |=> st.win[1] == $past(wbyte))
    else $error("second window lost");
  // control upper byte carries both source nibbles
  AST_CTRL_HI: assert property ( // R09
    wr && base == ADDR_CTRL && hi |=> st.ctrl[15:8] == $past(wbyte))
    else $error("control source byte lost");
  // any control write restarts both histories
  AST_RESTART: assert property ( // R18
    wr && base == ADDR_CTRL |=> st.restart)
    else $error("control write without restart");
  // control reads back whole
  AST_READ_CTRL: assert property ( // R10
    rd && base == ADDR_CTRL |=> rd_valid && rd_data == $past(st.ctrl))
    else $error("control read wrong");
  // first window reads back with upper byte zero
  AST_READ_WIN1: assert property ( // R06
    rd && base == ADDR_WIN1 |=> rd_valid && rd_data == {8'h00, $past(st.win[0])})
    else $error("first window read wrong");
  // second threshold reads back whole, sign included
  AST_READ_THR2: assert property ( // R03
    rd && base == ADDR_THR2 |=> rd_valid && rd_data == $past(st.thr[1]))
    else $error("second threshold read wrong");
  // active-low on line b follows inverted OR of flags
  AST_IND_LOW: assert property ( // R14
    st.ctrl[CTL_IND_EN] && !st.ctrl[CTL_IND_POL] && st.ctrl[CTL_IND_SEL]
    |=> !digital_io_line_b_oe_b && digital_io_line_b == !$past(|st.flags))
    else $error("active-low level wrong on line b");
  // active-low on line a follows inverted OR of flags
  AST_IND_LOW_A: assert property ( // R14
    st.ctrl[CTL_IND_EN] && !st.ctrl[CTL_IND_POL] && !st.ctrl[CTL_IND_SEL]
    |=> !digital_io_line_a_oe_b && digital_io_line_a == !$past(|st.flags))
    else $error("active-low level wrong on line a");
  // line select clear routes to line a only
  AST_IND_LINE_A: assert property ( // R15
    st.ctrl[CTL_IND_EN] && !st.ctrl[CTL_IND_SEL]
    |=> !digital_io_line_a_oe_b && digital_io_line_b_oe_b)
    else $error("indicator not on line a");
  // tick only where the divider wraps
  AST_TICK_PHASE: assert property ( // R16
    sample_tick |-> st.div_cnt == '0)
    else $error("tick off the divider wrap");
  // divider never passes its last count
  AST_DIV_RANGE: assert property ( // R16
    st.div_cnt <= DIV_LAST)
    else $error("divider out of range");
endmodule : dsa_top
`default_nettype wire
